// ==== bench/cfg_bank_assertions.sv ====
// port-level checks of the serial configuration register bank
`timescale 1ns/1ps
`default_nettype none
module cfg_bank_assertions (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic serial_out_lane_a_o,
  input wire logic serial_out_lane_a_oe_n_o,
  input wire logic partial_power_down_o,
  input wire logic full_power_down_o,
  input wire logic [7:0] serial_out_lane_select_o,
  input wire logic [7:0] output_format_select_o,
  input wire logic [7:0] reference_source_select_o,
  input wire logic [8:0] ref_dac_a_o,
  input wire logic [8:0] ref_dac_b_o,
  input wire logic [7:0] analog_input_setup_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // eight idle cycles outlast the synchroniser and the decode delay
  sequence cs_idle; cs_n_i [*8]; endsequence
  sequence cs_busy; !cs_n_i [*8]; endsequence
  sequence sclk_high; (sclk_i && !cs_n_i) [*4]; endsequence
  AST_RST_ZERO: assert property (disable iff (1'b0) !rstn_i |=>
    !partial_power_down_o && !full_power_down_o && ref_dac_a_o == 9'h000) else $error("reset");
  AST_RST_PIN: assert property (disable iff (1'b0) !rstn_i |=>
    serial_out_lane_a_oe_n_o && !serial_out_lane_a_o) else $error("reset pin");
  AST_OE_IDLE: assert property (cs_idle |-> serial_out_lane_a_oe_n_o)
    else $error("lane driven while idle");
  AST_OE_BUSY: assert property (cs_busy |-> !serial_out_lane_a_oe_n_o)
    else $error("lane released in frame");
  AST_PWR_QUIET: assert property (cs_idle |=> $stable(partial_power_down_o)
    && $stable(full_power_down_o)) else $error("power moved while idle");
  AST_CFG_QUIET: assert property (cs_idle |=> $stable(serial_out_lane_select_o)
    && $stable(analog_input_setup_o)) else $error("setup moved while idle");
  AST_DAC_QUIET: assert property (cs_idle |=> $stable(ref_dac_a_o)
    && $stable(ref_dac_b_o)) else $error("dac moved while idle");
  AST_SDO_HOLD: assert property (sclk_high |-> $stable(serial_out_lane_a_o))
    else $error("lane changed with clock high");
endmodule
bind cfg_bank cfg_bank_assertions i_chk (.*);
`default_nettype wire

// ==== bench/spi_host.sv ====
// host controller model: sends frames, captures the first byte on lane a
`timescale 1ns/1ps
`default_nettype none
module spi_host (
  input wire logic clk_sys_i,
  input wire logic sdo_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  logic [7:0] rx;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic half;
    repeat (4) @(negedge clk_sys_i);
  endtask
  // msb first, low n bits of w; lane sampled late in the high half to let it settle
  task automatic frame(input logic [23:0] w, input int n);
    cs_n_o = 1'b0;
    half();
    half();
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = w[i];
      half();
      sclk_o = 1'b1;
      half();
      if (i >= n - 8) rx = {rx[6:0], sdo_i};
      sclk_o = 1'b0;
    end
    half();
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    half();
    half();
  endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the serial configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cfg_bank_pkg::*;
  logic clk_sys_i, rstn_i, cs_n_i, sclk_i, sdi_i, serial_out_lane_a_o;
  logic serial_out_lane_a_oe_n_o, partial_power_down_o, full_power_down_o;
  logic [7:0] serial_out_lane_select_o, output_format_select_o, reference_source_select_o;
  logic [7:0] analog_input_setup_o;
  logic [8:0] ref_dac_a_o, ref_dac_b_o;
  logic lane_seen;
  int n_fail = 0;
  int cmp_count = 0;
  // 8'h06 is unmapped and only read; power stays locked while the key is wrong
  logic [7:0] adr [11] = '{ADDR_POWER, ADDR_UNLOCK, ADDR_LANE, ADDR_FORMAT, ADDR_REFSRC,
    ADDR_DAC_A_LO, ADDR_DAC_A_HI, ADDR_DAC_B_LO, ADDR_DAC_B_HI, ADDR_INPUT, 8'h06};
  logic [7:0] msk [11] = '{8'h00, 8'h0F, 8'h01, 8'h01, 8'h01, 8'hFF, 8'h01, 8'hFF, 8'h01,
    8'hFF, 8'h00};
  cfg_bank i_cfg_bank (.*);
  // a released lane shows the inverse of its last bit, so sampling it shows up
  assign lane_seen = serial_out_lane_a_oe_n_o ? !serial_out_lane_a_o : serial_out_lane_a_o;
  spi_host i_spi_host (.clk_sys_i(clk_sys_i), .sdo_i(lane_seen), .cs_n_o(cs_n_i),
    .sclk_o(sclk_i), .sdi_o(sdi_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] op, input logic [7:0] a, input logic [7:0] d);
    i_spi_host.frame({4'h0, op, a, d}, 20);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wr(OP_READ, a, 8'h00);
    wr(OP_NOP, 8'h00, 8'h00);
    chk({1'b0, i_spi_host.rx}, {1'b0, e});
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    rstn_i = 1'b0;
    repeat (16) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    for (int i = 0; i < 11; i++) rd(adr[i], 8'h00);
    $display("reset values done");
    for (int i = 0; i < 10; i++) wr(OP_WRITE, adr[i], 8'hA5);
    for (int i = 0; i < 11; i++) rd(adr[i], 8'hA5 & msk[i]);
    chk(ref_dac_a_o, 9'h1A5);
    chk({1'b0, serial_out_lane_select_o}, 9'h001);
    chk({1'b0, analog_input_setup_o}, 9'h0A5);
    chk({1'b0, output_format_select_o}, 9'h001);
    chk({1'b0, reference_source_select_o}, 9'h001);
    chk(ref_dac_b_o, 9'h1A5);
    $display("write masks done");
    wr(OP_WRITE, ADDR_UNLOCK, 8'h09);
    wr(OP_SET, ADDR_POWER, 8'hFF);
    chk({7'h00, partial_power_down_o, full_power_down_o}, 9'h003);
    wr(OP_CLEAR, ADDR_POWER, 8'h04);
    rd(ADDR_POWER, 8'h02);
    wr(4'h5, ADDR_POWER, 8'h00);
    i_spi_host.frame({4'h0, OP_WRITE, ADDR_POWER, 8'h00}, 19);
    rd(ADDR_POWER, 8'h02);
    i_spi_host.frame({4'hF, OP_WRITE, ADDR_POWER, 8'h00}, 24);
    chk({7'h00, partial_power_down_o, full_power_down_o}, 9'h000);
    wr(OP_SET, ADDR_POWER, 8'h02);
    wr(OP_WRITE, ADDR_UNLOCK, 8'h00);
    wr(OP_WRITE, ADDR_POWER, 8'hFF);
    wr(OP_SET, ADDR_POWER, 8'hFF);
    wr(OP_CLEAR, ADDR_POWER, 8'hFF);
    chk({7'h00, partial_power_down_o, full_power_down_o}, 9'h001);
    rd(ADDR_POWER, 8'h02);
    $display("power controls done");
    // second reset in mid-run: every register comes back to zero
    rstn_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    chk({7'h00, partial_power_down_o, full_power_down_o}, 9'h000);
    chk(ref_dac_b_o, 9'h000);
    rd(ADDR_DAC_B_LO, 8'h00);
    $display("mid-run reset done");
    complete_run();
  end
  // a hang ends the run as a mismatch
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire

// ==== rtl/cfg_bank.sv ====
// serial-programmed configuration register bank of a dual converter
`timescale 1ns/1ps
`default_nettype none
// How it works
// (RULE1) host leaves unlisted addresses alone
// (RULE2) power and unlock registers at 4h, 5h
// (RULE3) lane, format, reference at Dh, 11h, 20h
// (RULE4) reference dac bytes at 24h to 27h
// (RULE5) analog input setup at 28h
// (RULE6) every register resets to zero
// (RULE7) power bit 2 gives partial power-down
// (RULE8) power bit 1 gives full power-down
// (RULE9) key 1001 in bits 3-0 unlocks power
// (RULE10) locked power register ignores all writes
// (RULE11) reserved addresses read zero, ignore writes
// (RULE12) opcode nibble selects nop/write/read/set/clear
// (RULE13) last 20 bits decoded at select rise
// (RULE14) read data leaves lane a next frame
// (RULE15) host writes key before power bits
module cfg_bank
  import cfg_bank_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic serial_out_lane_a_o,
  output logic serial_out_lane_a_oe_n_o,
  output logic partial_power_down_o,
  output logic full_power_down_o,
  output logic [7:0] serial_out_lane_select_o,
  output logic [7:0] output_format_select_o,
  output logic [7:0] reference_source_select_o,
  output logic [8:0] ref_dac_a_o,
  output logic [8:0] ref_dac_b_o,
  output logic [7:0] analog_input_setup_o
);
  localparam int NREG = 10;
  localparam logic [7:0] ADDRS [NREG] = '{ADDR_POWER, ADDR_UNLOCK, ADDR_LANE,
    ADDR_FORMAT, ADDR_REFSRC, ADDR_DAC_A_LO, ADDR_DAC_A_HI, ADDR_DAC_B_LO,
    ADDR_DAC_B_HI, ADDR_INPUT};
  // writable bits per register; all else reads zero
  localparam logic [7:0] MASKS [NREG] = '{POWER_MASK, UNLOCK_MASK, BIT0_MASK,
    BIT0_MASK, BIT0_MASK, FULL_MASK, BIT0_MASK, FULL_MASK, BIT0_MASK, FULL_MASK};

  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    logic [FRAME_BITS-1:0] shift;
    logic [4:0] count;
    logic [7:0] out_shift;
    logic read_pending;
    logic [7:0] read_data;
    logic sclk_q;
    logic cs_q;
    logic sdo;
    logic oe_n;
  } bank_state_t;
  bank_state_t st, next_st;

  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  pin_sync u_cs (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .pin_i(cs_n_i),
    .level_o(cs_n_s)
  );
  pin_sync u_sclk (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .pin_i(sclk_i),
    .level_o(sclk_s)
  );
  pin_sync u_sdi (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .pin_i(sdi_i),
    .level_o(sdi_s)
  );

  logic [NREG-1:0] hit;
  logic [3:0] opcode;
  logic [7:0] addr;
  logic [7:0] data;
  logic unlocked;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;

  assign opcode = st.shift[19:16]; // RULE12
  assign addr = st.shift[15:8];
  assign data = st.shift[7:0];
  assign unlocked = (st.regs[1][3:0] == UNLOCK_PATTERN); // RULE9
  assign sclk_rise = sclk_s && !st.sclk_q;
  assign sclk_fall = !sclk_s && st.sclk_q;
  assign cs_rise = cs_n_s && !st.cs_q;
  assign cs_fall = !cs_n_s && st.cs_q;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_dec
      assign hit[g] = (addr == ADDRS[g]); // RULE2 RULE3 RULE4 RULE5
    end
  endgenerate

  always_comb begin
    logic [7:0] cur;
    logic [7:0] rd;
    cur = '0;
    rd = '0;
    next_st = st;
    next_st.sclk_q = sclk_s;
    next_st.cs_q = cs_n_s;
    // sdi sampled on sclk rise, lane a changes on sclk fall
    if (!cs_n_s && sclk_rise) begin
      next_st.shift = {st.shift[FRAME_BITS-2:0], sdi_s}; // RULE13
      if (st.count != CNT_FULL) begin
        next_st.count = st.count + 5'd1;
      end
    end
    if (cs_fall) begin
      next_st.count = '0;
      next_st.oe_n = 1'b0;
      // read answer goes first on lane a; zero otherwise
      next_st.sdo = st.read_pending ? st.read_data[7] : 1'b0; // RULE14
      next_st.out_shift = st.read_pending ? {st.read_data[6:0], 1'b0} : '0;
      next_st.read_pending = 1'b0;
    end else if (!cs_n_s && sclk_fall) begin
      next_st.sdo = st.out_shift[7];
      next_st.out_shift = {st.out_shift[6:0], 1'b0};
    end
    if (cs_rise) begin
      next_st.oe_n = 1'b1;
      // short frames are thrown away whole
      if (st.count == CNT_FULL) begin // RULE13
        for (int i = 0; i < NREG; i++) begin
          if (hit[i]) begin
            cur = st.regs[i];
            rd = st.regs[i];
            // power register needs the key; others always writable
            if (i != 0 || unlocked) begin // RULE10 RULE15
              case (opcode)
                OP_WRITE: cur = data;
                OP_SET: cur = st.regs[i] | data;
                OP_CLEAR: cur = st.regs[i] & ~data; // clear_masked_cmd
                default: cur = st.regs[i];
              endcase
            end
            next_st.regs[i] = cur & MASKS[i]; // RULE9 RULE10
          end
        end
        // unmapped addresses fall out with rd zero
        if (opcode == OP_READ) begin // RULE11 RULE14
          next_st.read_pending = 1'b1;
          next_st.read_data = rd;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st <= '0; // RULE6
      st.sclk_q <= 1'b0;
      // the synchroniser also resets low, so an idle select gives no false fall
      st.cs_q <= 1'b0;
      st.oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign serial_out_lane_a_o = st.sdo;
  assign serial_out_lane_a_oe_n_o = st.oe_n;
  assign partial_power_down_o = st.regs[0][PARTIAL_PD_BIT]; // RULE7
  assign full_power_down_o = st.regs[0][FULL_PD_BIT]; // RULE8
  assign serial_out_lane_select_o = st.regs[2];
  assign output_format_select_o = st.regs[3];
  assign reference_source_select_o = st.regs[4];
  assign ref_dac_a_o = {st.regs[6][0], st.regs[5]};
  assign ref_dac_b_o = {st.regs[8][0], st.regs[7]};
  assign analog_input_setup_o = st.regs[9];
endmodule
`default_nettype wire

// ==== rtl/cfg_bank_pkg.sv ====
// constants shared by the serial configuration register bank
package cfg_bank_pkg;
  localparam int FRAME_BITS = 20;
  localparam logic [7:0] ADDR_POWER = 8'h04;
  localparam logic [7:0] ADDR_UNLOCK = 8'h05;
  localparam logic [7:0] ADDR_LANE = 8'h0D;
  localparam logic [7:0] ADDR_FORMAT = 8'h11;
  localparam logic [7:0] ADDR_REFSRC = 8'h20;
  localparam logic [7:0] ADDR_DAC_A_LO = 8'h24;
  localparam logic [7:0] ADDR_DAC_A_HI = 8'h25;
  localparam logic [7:0] ADDR_DAC_B_LO = 8'h26;
  localparam logic [7:0] ADDR_DAC_B_HI = 8'h27;
  localparam logic [7:0] ADDR_INPUT = 8'h28;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] POWER_MASK = 8'h06;
  localparam logic [7:0] UNLOCK_MASK = 8'h0F;
  localparam logic [7:0] BIT0_MASK = 8'h01;
  localparam logic [7:0] FULL_MASK = 8'hFF;
  localparam logic [3:0] UNLOCK_PATTERN = 4'h9;
  localparam int PARTIAL_PD_BIT = 2;
  localparam int FULL_PD_BIT = 1;
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [3:0] OP_READ = 4'h2;
  localparam logic [3:0] OP_SET = 4'h3;
  localparam logic [3:0] OP_CLEAR = 4'h4;
  localparam logic [4:0] CNT_FULL = 5'h14;
  localparam logic [2:0] SYNC_RESET = 3'h0;
endpackage

// ==== rtl/pin_sync.sv ====
// three-stage synchroniser with agreement between the last two stages
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import cfg_bank_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic pin_i,
  output logic level_o
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } sync_state_t;
  sync_state_t st, next_st;
  // the first stage is read only by the second one
  always_comb begin
    next_st = st;
    next_st.stage = {st.stage[1:0], pin_i};
    if (st.stage[1] == st.stage[2]) begin
      next_st.level = st.stage[2];
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st <= '{stage: SYNC_RESET, level: 1'b0};
    end else begin
      st <= next_st;
    end
  end
  assign level_o = st.level;
endmodule
`default_nettype wire
